// [design/rsw_pkg.sv]
// shared constants and types for the reset supervisor with watchdog
`default_nettype none
package rsw_pkg;
    localparam int unsigned CLK_KHZ         = 40000;
    // times as printed, in their own units
    localparam int unsigned STRETCH_MS      = 250;
    localparam int unsigned WD_GND_MS       = 150;
    localparam int unsigned WD_OPEN_MS      = 600;
    localparam int unsigned WD_SUPPLY_MS    = 1200;
    localparam int unsigned PB_MAX_MS       = 20;
    localparam int unsigned DEBOUNCE_MS     = 5;
    localparam int unsigned FAIL_DETECT_US  = 175;
    // derived cycle counts
    localparam int unsigned STRETCH_CYCLES  = STRETCH_MS * CLK_KHZ;
    localparam int unsigned WD_GND_CYCLES   = WD_GND_MS * CLK_KHZ;
    localparam int unsigned WD_OPEN_CYCLES  = WD_OPEN_MS * CLK_KHZ;
    localparam int unsigned WD_SUPPLY_CYCLES = WD_SUPPLY_MS * CLK_KHZ;
    localparam int unsigned PB_MAX_CYCLES   = PB_MAX_MS * CLK_KHZ;
    localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_MS * CLK_KHZ;
    localparam int unsigned FAIL_DETECT_CYCLES = FAIL_DETECT_US * CLK_KHZ / 1000;
    localparam int unsigned COUNT_W         = 26;

    typedef logic [COUNT_W-1:0] count_type;

    typedef enum logic [1:0]
    {
        TSEL_GND    = 2'h0,
        TSEL_OPEN   = 2'h1,
        TSEL_SUPPLY = 2'h2
    } tsel_type;

    // gray along hold -> stretch -> run
    typedef enum logic [1:0]
    {
        PH_HOLD    = 2'h0,
        PH_STRETCH = 2'h1,
        PH_RUN     = 2'h3
    } phase_type;

    typedef struct packed
    {
        phase_type phase;
        count_type stretch;
        count_type wd;
        logic      kick_prev;
        logic      reset_out;
        logic      reset_oe_n;
        logic      drive_low;
    } sup_state_type;

    typedef struct packed
    {
        logic      pressed;
        count_type cnt;
    } deb_state_type;

    localparam logic KICK_PREV_RST = 1'h1;
endpackage : rsw_pkg
`default_nettype wire

// [design/debounce_filter.sv]
// pushbutton debounce filter, active-low input, pressed level out
`default_nettype none
module debounce_filter
#(
    parameter int unsigned SETTLE_CYCLES = rsw_pkg::DEBOUNCE_CYCLES
)
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    // button
    input  wire logic raw_n_i,
    output logic      pressed_o
);

    rsw_pkg::deb_state_type st;
    rsw_pkg::deb_state_type next_st;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_st = st;
        // input must disagree with the filtered level for a full settle time
        if ((!raw_n_i) != st.pressed)
        begin
            if (st.cnt == rsw_pkg::count_type'(SETTLE_CYCLES - 1))
            begin
                next_st.pressed = !raw_n_i;
                next_st.cnt     = '0;
            end
            else
            begin
                next_st.cnt = st.cnt + 1'b1;
            end
        end
        else
        begin
            next_st.cnt = '0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign pressed_o = st.pressed;

    ////////////////////////////////////////////////////////////////////////
    a_debounce_hold : assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (!st.pressed && raw_n_i) |=> !st.pressed)
        else $error("filtered press appeared while button was released");

endmodule : debounce_filter
`default_nettype wire

// [design/reset_supervisor_watchdog.sv]
// reset supervisor: supply fail, pushbutton and watchdog reset sources
`default_nettype none
module reset_supervisor_watchdog
#(
    parameter int unsigned STRETCH_CYCLES   = rsw_pkg::STRETCH_CYCLES,
    parameter int unsigned WD_GND_CYCLES    = rsw_pkg::WD_GND_CYCLES,
    parameter int unsigned WD_OPEN_CYCLES   = rsw_pkg::WD_OPEN_CYCLES,
    parameter int unsigned WD_SUPPLY_CYCLES = rsw_pkg::WD_SUPPLY_CYCLES,
    parameter int unsigned DEBOUNCE_CYCLES  = rsw_pkg::DEBOUNCE_CYCLES
)
(
    // clock and reset
    input  wire logic       CLK_I,
    input  wire logic       ARST_N_I,
    // supply comparator results
    input  wire logic       SUPPLY_BELOW_HI_I,
    input  wire logic       SUPPLY_BELOW_LO_I,
    input  wire logic       SUPPLY_MARGIN_SELECT_I,
    // pushbutton and watchdog
    input  wire logic       PUSHBUTTON_RESET_N_I,
    input  wire logic       KICK_INPUT_I,
    input  wire logic [1:0] TIMEOUT_SELECT_I,
    // reset outputs
    output logic            RESET_O,
    output logic            RESET_N_O,
    output logic            RESET_N_OE_N_O
);

    rsw_pkg::sup_state_type st;
    rsw_pkg::sup_state_type next_st;
    logic                   pb_pressed;
    logic                   supply_fail;
    logic                   source_active;
    logic                   kick_fall;
    rsw_pkg::count_type     wd_last;

    ////////////////////////////////////////////////////////////////////////
    // last count of the selected watchdog period
    function automatic rsw_pkg::count_type timeout_last(input logic [1:0] sel);
        rsw_pkg::count_type r;
        r = rsw_pkg::count_type'(WD_OPEN_CYCLES - 1);
        // the unused code falls back to the middle range
        unique case (rsw_pkg::tsel_type'(sel))
            rsw_pkg::TSEL_GND:    r = rsw_pkg::count_type'(WD_GND_CYCLES - 1);
            rsw_pkg::TSEL_OPEN:   r = rsw_pkg::count_type'(WD_OPEN_CYCLES - 1);
            rsw_pkg::TSEL_SUPPLY: r = rsw_pkg::count_type'(WD_SUPPLY_CYCLES - 1);
            default:              r = rsw_pkg::count_type'(WD_OPEN_CYCLES - 1);
        endcase
        return r;
    endfunction : timeout_last

    ////////////////////////////////////////////////////////////////////////
    debounce_filter
    #(
        .SETTLE_CYCLES (DEBOUNCE_CYCLES)
    )
    u_debounce
    (
        .clk_i     (CLK_I),
        .arst_n_i  (ARST_N_I),
        .raw_n_i   (PUSHBUTTON_RESET_N_I),
        .pressed_o (pb_pressed)
    );

    ////////////////////////////////////////////////////////////////////////
    // tied margin gives the lower threshold
    assign supply_fail   = SUPPLY_MARGIN_SELECT_I ? SUPPLY_BELOW_LO_I : SUPPLY_BELOW_HI_I;
    assign source_active = supply_fail || pb_pressed;
    assign kick_fall     = st.kick_prev && !KICK_INPUT_I;
    assign wd_last       = timeout_last(TIMEOUT_SELECT_I);

    always_comb
    begin
        next_st           = st;
        next_st.kick_prev = KICK_INPUT_I;
        next_st.drive_low = 1'b0;
        unique case (st.phase)
            rsw_pkg::PH_HOLD:
            begin
                next_st.stretch = '0;
                next_st.wd      = '0;
                if (!source_active)
                begin
                    next_st.phase = rsw_pkg::PH_STRETCH;
                end
            end
            rsw_pkg::PH_STRETCH:
            begin
                next_st.wd = '0;
                if (source_active)
                begin
                    // a source coming back restarts the whole stretch
                    next_st.phase   = rsw_pkg::PH_HOLD;
                    next_st.stretch = '0;
                end
                else if (st.stretch == rsw_pkg::count_type'(STRETCH_CYCLES - 1))
                begin
                    next_st.phase     = rsw_pkg::PH_RUN;
                    next_st.reset_out = 1'b0;
                end
                else
                begin
                    next_st.stretch = st.stretch + 1'b1;
                end
            end
            rsw_pkg::PH_RUN:
            begin
                // no enable: only kicks keep this phase alive
                if (source_active)
                begin
                    next_st.phase     = rsw_pkg::PH_HOLD;
                    next_st.reset_out = 1'b1;
                    next_st.wd        = '0;
                end
                else if (kick_fall)
                begin
                    next_st.wd = '0;
                end
                else if (st.wd >= wd_last)
                begin
                    // select may shrink mid-count, so compare with >=
                    next_st.phase     = rsw_pkg::PH_STRETCH;
                    next_st.reset_out = 1'b1;
                    next_st.stretch   = '0;
                    next_st.wd        = '0;
                end
                else
                begin
                    next_st.wd = st.wd + 1'b1;
                end
            end
            default:
            begin
                next_st.phase     = rsw_pkg::PH_HOLD;
                next_st.reset_out = 1'b1;
            end
        endcase
        next_st.reset_oe_n = !next_st.reset_out;
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            st.phase      <= rsw_pkg::PH_HOLD;
            st.stretch    <= '0;
            st.wd         <= '0;
            st.kick_prev  <= rsw_pkg::KICK_PREV_RST;
            st.reset_out  <= 1'b1;
            st.reset_oe_n <= 1'b0;
            st.drive_low  <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign RESET_O        = st.reset_out;
    assign RESET_N_O      = st.drive_low;
    assign RESET_N_OE_N_O = st.reset_oe_n;

    ////////////////////////////////////////////////////////////////////////
    // helper: cycles since the last source release while reset is held
    // follows the next reset level so that watchdog and source stretches count alike
    rsw_pkg::count_type quiet_len;
    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            quiet_len <= '0;
        end
        else if (!next_st.reset_out || source_active)
        begin
            quiet_len <= '0;
        end
        else
        begin
            quiet_len <= quiet_len + 1'b1;
        end
    end

    a_fail_asserts : assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        supply_fail |=> RESET_O)
        else $error("supply fail did not assert reset next cycle");

    a_margin_pick : assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        (SUPPLY_MARGIN_SELECT_I && SUPPLY_BELOW_LO_I) |=> RESET_O && !RESET_N_OE_N_O)
        else $error("low threshold trip ignored");

    a_outputs_paired : assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        (RESET_N_OE_N_O == !RESET_O) && !RESET_N_O)
        else $error("reset outputs disagree");

    a_stretch_min : assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        $fell(RESET_O) |-> $past(quiet_len) == rsw_pkg::count_type'(STRETCH_CYCLES))
        else $error("reset released before full stretch");

    a_pb_response : assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        $rose(pb_pressed) |-> ##[0:1] RESET_O)
        else $error("debounced press did not assert reset");

    a_pb_holds : assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        pb_pressed |=> RESET_O && quiet_len == '0)
        else $error("stretch counted while button held");

    a_wd_cleared : assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        RESET_O |-> st.wd == '0)
        else $error("watchdog counted during reset");

    a_kick_restart : assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        (st.phase == rsw_pkg::PH_RUN && kick_fall && !source_active) |=> st.wd == '0 && !RESET_O)
        else $error("kick did not restart watchdog");

    a_wd_expiry : assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        (st.phase == rsw_pkg::PH_RUN && st.wd >= wd_last && !kick_fall) |=> RESET_O)
        else $error("watchdog expiry did not assert reset");

    a_wd_bound : assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        (st.phase == rsw_pkg::PH_RUN && $stable(TIMEOUT_SELECT_I)) |-> st.wd <= wd_last)
        else $error("watchdog count past selected period");

    a_release_full : assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        $fell(RESET_O) |-> st.wd == '0 ##1 (st.wd <= 26'h1))
        else $error("watchdog did not start from full period");

endmodule : reset_supervisor_watchdog
`default_nettype wire

// [dv/kick_source.sv]
// processor-side model: periodic watchdog kicks while out of reset
`default_nettype none
module kick_source
(
    // clock
    input  wire logic       clk_i,
    // reset pin level seen by the processor
    input  wire logic       reset_pin_n_i,
    // kick control from the bench
    input  wire logic       enable_i,
    input  wire logic [7:0] interval_i,
    // kick line
    output var  logic       kick_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial kick_o = 1'h1;
    ////////////////////////////////////////////////////////////////////////////
    // a processor held in reset runs no code, so it cannot kick
    always @(posedge clk_i)
    begin
        if (!reset_pin_n_i || !enable_i)
            cnt = 0;
        else
            cnt = (cnt + 1) % int'(interval_i);
        kick_o <= #2 !(enable_i && reset_pin_n_i && cnt == int'(interval_i) - 1);
    end
endmodule : kick_source
`default_nettype wire

// [dv/reset_supervisor_watchdog_tb_top.sv]
// bench for the reset supervisor with watchdog
`default_nettype none
module reset_supervisor_watchdog_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STRETCH = 20;
    localparam int DEB     = 4;
    logic       CLK_I = 1'h0;
    logic       ARST_N_I = 1'h0;
    logic       hi = 1'h0;
    logic       lo = 1'h0;
    logic       margin = 1'h0;
    logic       pb = 1'h1;
    logic       kick;
    logic [1:0] tsel = 2'h0;
    logic       en = 1'h1;
    logic [7:0] interval = 8'h0a;
    logic       RESET_O;
    logic       RESET_N_O;
    logic       RESET_N_OE_N_O;
    wire logic  pin_n = RESET_N_OE_N_O ? 1'h1 : RESET_N_O;
    int         err_count = 0;
    int         compares = 0;
    ////////////////////////////////////////////////////////////////////////////
    reset_supervisor_watchdog #(.STRETCH_CYCLES(STRETCH), .WD_GND_CYCLES(30), .WD_OPEN_CYCLES(60),
        .WD_SUPPLY_CYCLES(90), .DEBOUNCE_CYCLES(DEB)) u_reset_supervisor_watchdog
    (
        .CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .SUPPLY_BELOW_HI_I(hi), .SUPPLY_BELOW_LO_I(lo),
        .SUPPLY_MARGIN_SELECT_I(margin), .PUSHBUTTON_RESET_N_I(pb), .KICK_INPUT_I(kick),
        .TIMEOUT_SELECT_I(tsel), .RESET_O(RESET_O), .RESET_N_O(RESET_N_O), .RESET_N_OE_N_O(RESET_N_OE_N_O)
    );
    kick_source u_kick_source
    (
        .clk_i(CLK_I), .reset_pin_n_i(pin_n), .enable_i(en), .interval_i(interval), .kick_o(kick)
    );
    initial forever #12.5 CLK_I = ~CLK_I;
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge CLK_I);
        #2;
    endtask : step
    // bounded wait for a reset level; a miss ends the run when it must arrive
    task automatic count_until(input logic val, input int lim, input bit must, output int n);
        n = 0;
        while (RESET_O !== val && n < lim)
        begin
            step(1);
            n++;
        end
        if (must && RESET_O !== val)
        begin
            check(RESET_O, val);
            test_done();
        end
    endtask : count_until
    // complementary outputs checked on every cycle
    always @(negedge CLK_I)
        check({RESET_N_OE_N_O, RESET_N_O}, {~RESET_O, 1'h0});
    ////////////////////////////////////////////////////////////////////////////
    task automatic supply_case(input logic m);
        int n;
        margin = m;
        hi = m;
        step(5);
        check(RESET_O, 1'h0);
        lo = m;
        hi = 1'h1;
        count_until(1'h1, 8, 1, n);
        check(n <= 2, 1'h1);
        step(10);
        {hi, lo} = 2'h0;
        step(5);
        check(RESET_O, 1'h1);
        {hi, lo} = {1'h1, m};
        step(1);
        {hi, lo} = 2'h0;
        count_until(1'h0, 40, 1, n);
        check(n >= STRETCH + 1 && n <= STRETCH + 3, 1'h1);
    endtask : supply_case
    task automatic pb_case;
        int n;
        pb = 1'h0;
        step(DEB - 1);
        pb = 1'h1;
        count_until(1'h1, 10, 0, n);
        check(n, 10);
        pb = 1'h0;
        count_until(1'h1, 16, 1, n);
        check(n <= DEB + 3, 1'h1);
        step(30);
        pb = 1'h1;
        count_until(1'h0, 60, 1, n);
        check(n >= STRETCH + 1, 1'h1);
    endtask : pb_case
    // no kicks: expiry after the full selected period, then a full stretch
    task automatic wd_case(input logic [1:0] sel, input int period);
        int n;
        en = 1'h0;
        tsel = sel;
        margin = 1'h0;
        hi = 1'h1;
        step(2);
        hi = 1'h0;
        count_until(1'h0, 60, 1, n);
        count_until(1'h1, 200, 1, n);
        check(n >= period && n <= period + 2, 1'h1);
        count_until(1'h0, 60, 1, n);
        // expiry enters the stretch directly, with no hold step before it
        check(n >= STRETCH && n <= STRETCH + 2, 1'h1);
    endtask : wd_case
    task automatic kick_case;
        int n;
        tsel = 2'h0;
        interval = 8'h0c;
        en = 1'h1;
        count_until(1'h1, 150, 0, n);
        check(n, 150);
    endtask : kick_case
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        int n;
        step(3);
        ARST_N_I = 1'h1;
        count_until(1'h0, 60, 1, n);
        check(n >= STRETCH + 1, 1'h1);
        supply_case(1'h0);
        supply_case(1'h1);
        pb_case();
        wd_case(2'h0, 30);
        wd_case(2'h1, 60);
        wd_case(2'h2, 90);
        wd_case(2'h3, 60);
        kick_case();
        test_done();
    end
endmodule : reset_supervisor_watchdog_tb_top
`default_nettype wire
